// ===== logic/fws_cycle.sv
// module: one flash bus read or write cycle with strobe timing
`timescale 1ns/1ps
`default_nettype none
module fws_cycle import fws_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic req,
	input wire fws_req_type req_data,
	output logic ack,
	output logic [7:0] rdata,
	output var fws_pins_type pins,
	input wire logic [7:0] dq_in
);
	typedef enum logic [1:0] {
		E_IDLE = 2'b00,
		E_ACT = 2'b01,
		E_REC = 2'b10
	} fws_eng_type;

	fws_eng_type state;
	logic [5:0] cnt;
	logic is_wr;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= E_IDLE;
			cnt <= 6'h00;
			is_wr <= 1'b0;
			ack <= 1'b0;
			rdata <= 8'h00;
			pins <= '{addr: 20'h00000, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				dq_out: 8'h00, dq_drive_n: 1'b1};
		end else begin
			ack <= 1'b0;
			case (state)
				E_IDLE: begin
					if (req && !ack) begin
						is_wr <= req_data.wr;
						pins.addr <= req_data.addr;
						pins.cs_n <= 1'b0;
						pins.oe_n <= req_data.wr;
						pins.we_n <= !req_data.wr;
						pins.dq_out <= req_data.data;
						pins.dq_drive_n <= !req_data.wr;
						cnt <= req_data.wr ? T_WP_CYC : T_ACC_CYC;
						state <= E_ACT;
					end
				end
				E_ACT: begin
					if (cnt == 6'h01) begin
						if (!is_wr) begin
							rdata <= dq_in;
						end
						// both strobes rise so each status read is its own cycle
						pins.cs_n <= 1'b1;
						pins.oe_n <= 1'b1;
						pins.we_n <= 1'b1;
						cnt <= T_REC_CYC;
						state <= E_REC;
					end else begin
						cnt <= cnt - 6'h01;
					end
				end
				E_REC: begin
					if (cnt == 6'h01) begin
						pins.dq_drive_n <= 1'b1;
						ack <= 1'b1;
						state <= E_IDLE;
					end else begin
						cnt <= cnt - 6'h01;
					end
				end
				default: state <= E_IDLE;
			endcase
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_strobe_exclusive: assert property (!(!pins.oe_n && !pins.we_n))
		else $error("output and write strobes low together");
	a_read_separated: assert property (state == E_ACT && cnt == 6'h01 && !is_wr
		|=> pins.oe_n && pins.cs_n [*2])
		else $error("read strobes not released after a read");
endmodule : fws_cycle
`default_nettype wire

// ===== logic/fws_host.sv
// module: apb-controlled host that writes flash commands and polls write status
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - host polls at the program address or inside an erased sector
// - host takes final data only from the read after completion
// - host reads status twice and compares toggle bit; equal means done
// - still toggling with timeout bit high: recheck, still toggling means failure
// - after other work host restarts from the first double read
// - after a timeout failure host writes the reset command
// - host never skips erase window checks, not even with adds within 50 us
// - host checks erase window bit before and after each added sector erase
// - reset command is one write of f0 to any address
module fws_host import fws_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output var fws_pins_type flash_pins,
	input wire logic [7:0] dq_in,
	input wire logic ready_busy_in
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_CMD = 4'b0001,
		S_PRECHK = 4'b0010,
		S_POSTCHK = 4'b0011,
		S_RD1 = 4'b0100,
		S_RD2 = 4'b0101,
		S_FINAL = 4'b0110,
		S_RST = 4'b0111
	} fws_state_type;

	fws_state_type state;
	fws_op_type op;
	logic [19:0] target;
	logic [7:0] wdata;
	logic [2:0] step;
	logic recheck;
	logic [7:0] first_rd;
	logic [7:0] status_rd;
	logic [7:0] final_rd;
	logic done;
	logic fail;
	logic reject;
	logic eng_req;
	logic eng_ack;
	logic [7:0] eng_rdata;
	fws_req_type eng_cmd;
	logic apb_wr;
	logic start;
	logic toggling;

	assign apb_wr = psel && penable && pwrite;
	assign start = apb_wr && paddr == REG_CTRL && state == S_IDLE && pwdata[2:0] != OP_NONE;
	assign toggling = first_rd[BIT_TOGGLE] != eng_rdata[BIT_TOGGLE];
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == REG_CTRL || paddr == REG_ADDR
		|| paddr == REG_DATA || paddr == REG_STATUS);

	always_comb begin
		case (paddr)
			REG_CTRL: prdata = {29'h0, op};
			REG_ADDR: prdata = {12'h000, target};
			REG_DATA: prdata = {24'h000000, wdata};
			REG_STATUS: prdata = {8'h00, final_rd, status_rd, 3'h0, ready_busy_in, reject,
				fail, done, state != S_IDLE};
			default: prdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			target <= 20'h00000;
			wdata <= 8'h00;
		end else if (apb_wr && state == S_IDLE) begin
			if (paddr == REG_ADDR) begin
				target <= pwdata[19:0];
			end
			if (paddr == REG_DATA) begin
				wdata <= pwdata[7:0];
			end
		end
	end

	// every status read goes to the operation's own address
	always_comb begin
		eng_req = state != S_IDLE;
		if (state == S_CMD || state == S_RST) begin
			eng_cmd = fws_seq(state == S_RST ? OP_RESET : op, target, wdata, step);
		end else begin
			eng_cmd = '{wr: 1'b0, addr: target, data: 8'h00};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= S_IDLE;
			op <= OP_NONE;
			step <= 3'h0;
			recheck <= 1'b0;
			first_rd <= 8'h00;
			status_rd <= 8'h00;
			final_rd <= 8'h00;
			done <= 1'b0;
			fail <= 1'b0;
			reject <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (start) begin
						op <= fws_op_type'(pwdata[2:0]);
						step <= 3'h0;
						recheck <= 1'b0;
						done <= 1'b0;
						fail <= 1'b0;
						reject <= 1'b0;
						if (pwdata[2:0] == OP_ADD) begin
							state <= S_PRECHK;
						end else if (pwdata[2:0] == OP_POLL) begin
							state <= S_RD1;
						end else begin
							state <= S_CMD;
						end
					end
				end
				S_CMD: begin
					if (eng_ack) begin
						step <= step + 3'h1;
						if (step == fws_last(op)) begin
							if (op == OP_ADD) begin
								state <= S_POSTCHK;
							end else if (op == OP_PROGRAM || op == OP_CHIP) begin
								state <= S_RD1;
							end else begin
								done <= 1'b1;
								state <= S_IDLE;
							end
						end
					end
				end
				S_PRECHK: begin
					if (eng_ack) begin
						status_rd <= eng_rdata;
						// erasing has begun: the added sector would be ignored
						if (eng_rdata[BIT_WINDOW]) begin
							reject <= 1'b1;
							done <= 1'b1;
							state <= S_IDLE;
						end else begin
							state <= S_CMD;
						end
					end
				end
				S_POSTCHK: begin
					if (eng_ack) begin
						status_rd <= eng_rdata;
						reject <= eng_rdata[BIT_WINDOW];
						done <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_RD1: begin
					if (eng_ack) begin
						first_rd <= eng_rdata;
						state <= S_RD2;
					end
				end
				S_RD2: begin
					if (eng_ack) begin
						status_rd <= eng_rdata;
						if (!toggling) begin
							state <= S_FINAL;
						end else if (recheck) begin
							fail <= 1'b1;
							state <= S_RST;
						end else if (eng_rdata[BIT_TIMEOUT]) begin
							recheck <= 1'b1;
							state <= S_RD1;
						end else begin
							state <= S_RD1;
						end
					end
				end
				S_FINAL: begin
					if (eng_ack) begin
						final_rd <= eng_rdata;
						done <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_RST: begin
					if (eng_ack) begin
						done <= 1'b1;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	fws_cycle u_cycle (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.req(eng_req),
		.req_data(eng_cmd),
		.ack(eng_ack),
		.rdata(eng_rdata),
		.pins(flash_pins),
		.dq_in(dq_in)
	);

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence rd2_done_s;
		state == S_RD2 && eng_ack;
	endsequence

	a_poll_address: assert property (eng_req && !eng_cmd.wr |-> eng_cmd.addr == target)
		else $error("status read at wrong address");
	a_final_after: assert property (rd2_done_s ##0 !toggling |=> state == S_FINAL
		##1 (state == S_FINAL) [*3])
		else $error("final data not taken from a later read");
	a_double_read: assert property (state == S_RD1 && eng_ack |=> state == S_RD2)
		else $error("toggle decision without second read");
	a_timeout_recheck: assert property (rd2_done_s ##0 toggling && !recheck
		&& eng_rdata[BIT_TIMEOUT] |=> state == S_RD1 && recheck)
		else $error("timeout bit seen but no recheck");
	a_restart_pair: assert property (rd2_done_s ##0 toggling && !recheck
		&& !eng_rdata[BIT_TIMEOUT] |=> state == S_RD1 && !recheck)
		else $error("polling not restarted from first read");
	a_fail_reset: assert property (rd2_done_s ##0 toggling && recheck
		|=> state == S_RST && fail)
		else $error("failure without reset command");
	a_reset_word: assert property (state == S_RST && eng_req
		|-> eng_cmd.wr && eng_cmd.data == CMD_RESET)
		else $error("reset command is not a single f0 write");
	a_window_pre: assert property (state == S_PRECHK && eng_ack && eng_rdata[BIT_WINDOW]
		|=> state == S_IDLE && reject)
		else $error("added sector erase sent after erasing began");
	a_window_post: assert property (state == S_CMD && op == OP_ADD && eng_ack
		|=> state == S_POSTCHK ##[1:40] state == S_IDLE)
		else $error("window bit not checked after added sector erase");
endmodule : fws_host
`default_nettype wire

// ===== logic/fws_pkg.sv
// package: flash status host constants, types and command table
package fws_pkg;
	localparam int CLK_MHZ = 250;
	localparam int T_ACC_NS = 90;
	localparam int T_WP_NS = 35;
	localparam int T_REC_NS = 20;
	localparam logic [5:0] T_ACC_CYC = 6'((T_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [5:0] T_WP_CYC = 6'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [5:0] T_REC_CYC = 6'((T_REC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_ADDR = 12'h004;
	localparam logic [11:0] REG_DATA = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00c;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_REJECT = 3;
	localparam int ST_RDY = 4;
	localparam int BIT_POLL = 7;
	localparam int BIT_TOGGLE = 6;
	localparam int BIT_TIMEOUT = 5;
	localparam int BIT_WINDOW = 3;
	localparam logic [19:0] UNLOCK_A1 = 20'h00555;
	localparam logic [19:0] UNLOCK_A2 = 20'h002aa;
	localparam logic [7:0] UNLOCK_D1 = 8'haa;
	localparam logic [7:0] UNLOCK_D2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_SECTOR = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [2:0] LAST_LONG = 3'h5;
	localparam logic [2:0] LAST_PROG = 3'h3;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_PROGRAM = 3'b001,
		OP_SECTOR = 3'b010,
		OP_ADD = 3'b011,
		OP_CHIP = 3'b100,
		OP_RESET = 3'b101,
		OP_POLL = 3'b110
	} fws_op_type;

	typedef struct packed {
		logic wr;
		logic [19:0] addr;
		logic [7:0] data;
	} fws_req_type;

	typedef struct packed {
		logic [19:0] addr;
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic [7:0] dq_out;
		logic dq_drive_n;
	} fws_pins_type;

	function automatic fws_req_type fws_seq(fws_op_type op, logic [19:0] a, logic [7:0] d,
		logic [2:0] step);
		fws_req_type r;
		r = '{wr: 1'b1, addr: UNLOCK_A1, data: UNLOCK_D1};
		if (op == OP_RESET) begin
			r.data = CMD_RESET;
		end else if (op == OP_ADD) begin
			r.addr = a;
			r.data = CMD_SECTOR;
		end else begin
			case (step)
				3'h1: begin
					r.addr = UNLOCK_A2;
					r.data = UNLOCK_D2;
				end
				3'h2: r.data = (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE;
				3'h3: begin
					if (op == OP_PROGRAM) begin
						r.addr = a;
						r.data = d;
					end
				end
				3'h4: begin
					r.addr = UNLOCK_A2;
					r.data = UNLOCK_D2;
				end
				3'h5: begin
					r.addr = (op == OP_SECTOR) ? a : UNLOCK_A1;
					r.data = (op == OP_SECTOR) ? CMD_SECTOR : CMD_CHIP;
				end
				default: r.data = UNLOCK_D1;
			endcase
		end
		return r;
	endfunction : fws_seq

	function automatic logic [2:0] fws_last(fws_op_type op);
		case (op)
			OP_PROGRAM: return LAST_PROG;
			OP_SECTOR, OP_CHIP: return LAST_LONG;
			default: return 3'h0;
		endcase
	endfunction : fws_last
endpackage : fws_pkg

// ===== test/fws_flash_model.sv
// flash device model answering commands and status reads
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model import fws_pkg::*; #(
	parameter int BUSY_RD = 4,
	parameter int WIN_RD = 1,
	parameter logic [6:0] PROT_SEC = 7'h7f
) (
	input wire fws_pins_type pins,
	output logic [7:0] dq,
	output logic ready_busy_out
);
	logic [7:0] mem [logic [19:0]];
	logic [127:0] sel = '0;
	logic [7:0] pd = 8'h00;
	logic tog = 1'b0;
	logic tog2 = 1'b0;
	logic fail = 1'b0;
	int mode = 0;
	int cnt = 0;
	int nw = 0;
	wire logic rd_n;
	assign rd_n = pins.cs_n | pins.oe_n;
	assign ready_busy_out = (mode == 0);
	initial begin
		dq = 8'h00;
		mem[20'hfe000] = 8'h3c;
	end
	function automatic logic [7:0] rd(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction : rd
	// commands take effect at the end of the write strobe
	always @(posedge pins.we_n) begin : wr
		logic [19:0] a;
		logic [7:0] d;
		a = pins.addr;
		d = pins.dq_out;
		if (d == CMD_RESET && (mode == 0 || fail)) begin
			mode = 0;
			fail = 1'b0;
			nw = 0;
		end else if (mode == 2 && d == CMD_SECTOR) begin
			sel[a[19:13]] = 1'b1;
			cnt = 0;
		end else if (mode == 0) begin
			case (nw)
				0: nw = (d == UNLOCK_D1) ? 1 : 0;
				1: nw = (d == UNLOCK_D2) ? 2 : 0;
				2: nw = (d == CMD_PROGRAM) ? 3 : (d == CMD_ERASE) ? 4 : 0;
				3: begin
					nw = 0;
					pd = d;
					mode = 1;
					cnt = BUSY_RD;
					if (a[19:13] != PROT_SEC && (d & ~rd(a)) != 8'h00) begin
						fail = 1'b1;
					end else if (a[19:13] != PROT_SEC) begin
						mem[a] = d;
					end
				end
				4: nw = (d == UNLOCK_D1) ? 5 : 0;
				5: nw = (d == UNLOCK_D2) ? 6 : 0;
				default: begin
					nw = 0;
					sel = {128{d == CMD_CHIP}};
					sel[a[19:13]] = 1'b1;
					mode = (d == CMD_CHIP) ? 3 : (d == CMD_SECTOR) ? 2 : 0;
					cnt = (d == CMD_CHIP) ? BUSY_RD : 0;
				end
			endcase
		end
	end
	// one read each time both strobes fall together
	always @(negedge rd_n) begin : rdc
		if (mode == 1 && cnt == 0 && !fail) mode = 0;
		if (mode == 3 && cnt == 0) begin
			foreach (mem[k]) if (sel[k[19:13]] && k[19:13] != PROT_SEC) mem[k] = 8'hff;
			mode = 0;
		end
		if (mode == 2) cnt++;
		if (mode == 2 && cnt > WIN_RD) begin
			mode = 3;
			cnt = BUSY_RD;
		end
		tog = tog ^ (mode != 0);
		if (mode >= 2 && sel[pins.addr[19:13]]) tog2 = ~tog2;
		if (mode == 0) dq = rd(pins.addr);
		else if (mode == 1) dq = {~pd[7], tog, fail && cnt == 0, 5'h00};
		else dq = {1'b0, tog, 1'b0, 1'b0, mode == 3, tog2, 2'h0};
		if (cnt > 0 && mode != 2) cnt--;
	end
	// no pull-up on the data pins once released
	always @(posedge rd_n) dq = ~dq;
endmodule : fws_flash_model
`default_nettype wire

// ===== test/tb_fws_host.sv
// testbench driving the status host against the flash model
`timescale 1ns/1ps
`default_nettype none
module tb_fws_host import fws_pkg::*; ();
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic [31:0] s;
	logic pready;
	logic pslverr;
	logic e;
	logic rb;
	fws_pins_type pins;
	logic [7:0] dq_f;
	wire logic [7:0] dq_in;
	int bad_count = 0;
	int n_compared = 0;
	assign dq_in = pins.dq_drive_n ? dq_f : pins.dq_out;
	always #2 core_clk = ~core_clk;
	fws_host DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_pins(pins), .dq_in(dq_in), .ready_busy_in(rb));
	fws_flash_model flash (.pins(pins), .dq(dq_f), .ready_busy_out(rb));
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; answer taken at the rising edge that sees pready high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic r;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			r = pready;
			s = prdata;
			e = pslverr;
		end while (r !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic run(input logic [2:0] op, input logic [19:0] a, input logic [7:0] d);
		int n;
		n = 0;
		apb(1'b1, REG_ADDR, {12'h000, a});
		apb(1'b1, REG_DATA, {24'h000000, d});
		apb(1'b1, REG_CTRL, {29'h00000000, op});
		do begin
			apb(1'b0, REG_STATUS, 32'h00000000);
			n++;
		end while (s[ST_BUSY] !== 1'b0 && n < 5000);
		// a host that never finishes counts as a mismatch
		if (s[ST_BUSY] !== 1'b0) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, s, 32'h00000000);
		end
	endtask : run
	task automatic t_program;
		run(3'h1, 20'h01234, 8'h5a);
		chk(s[23:16], 8'h5a);
		chk(s[2:0], 3'h2);
		chk(s[4], 1'b1);
	endtask : t_program
	task automatic t_fail;
		run(3'h1, 20'h01234, 8'h7f);
		chk(s[2:0], 3'h6);
		chk(flash.mode, 0);
		chk(flash.rd(20'h01234), 8'h5a);
	endtask : t_fail
	task automatic t_protect;
		run(3'h1, 20'hfe000, 8'h00);
		chk(s[2:0], 3'h2);
		chk(s[23:16], 8'h3c);
	endtask : t_protect
	task automatic t_sector;
		run(3'h1, 20'h02000, 8'h00);
		run(3'h1, 20'h04000, 8'h00);
		run(3'h1, 20'h06000, 8'h0f);
		run(3'h2, 20'h02000, 8'h00);
		apb(1'b0, REG_STATUS, 32'h00000000);
		chk(s[4], 1'b0);
		run(3'h3, 20'h04000, 8'h00);
		chk(s[3], 1'b0);
		chk(s[11], 1'b0);
		run(3'h3, 20'h06000, 8'h00);
		chk(s[3], 1'b1);
		chk(s[11], 1'b1);
		run(3'h6, 20'h02000, 8'h00);
		chk(s[23:16], 8'hff);
		chk(flash.rd(20'h04000), 8'hff);
		chk(flash.rd(20'h06000), 8'h0f);
	endtask : t_sector
	task automatic t_chip;
		run(3'h4, 20'h00000, 8'h00);
		chk(s[2:0], 3'h2);
		chk(flash.rd(20'h06000), 8'hff);
		chk(flash.rd(20'hfe000), 8'h3c);
	endtask : t_chip
	task automatic t_bus;
		logic [31:0] v;
		run(3'h5, 20'h00000, 8'h00);
		chk(flash.mode, 0);
		v = s;
		apb(1'b1, REG_STATUS, 32'hffffffff);
		apb(1'b0, REG_STATUS, 32'h00000000);
		chk(s, v);
		apb(1'b0, 12'h010, 32'h00000000);
		chk(e, 1'b1);
		chk(s, 32'h00000000);
	endtask : t_bus
	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_program();
		t_fail();
		t_protect();
		t_sector();
		t_chip();
		t_bus();
		stop_test();
	end
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end
endmodule : tb_fws_host
`default_nettype wire
